/* src/fcsc_pkg.sv */
package fcsc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_PROT = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_CMD = 8'h0c;
  localparam logic [7:0] OFF_DIV = 8'h10;
  localparam logic [7:0] OFF_SEC = 8'h14;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;
  // field positions
  localparam int KWE_BIT = 5;
  localparam int CBEF_BIT = 7;
  localparam int CCF_BIT = 6;
  localparam int PVIOL_BIT = 5;
  localparam int ACCERR_BIT = 4;
  localparam int BLANK_BIT = 2;
  localparam int DIVIDER_LOADED_BIT = 7;
  localparam int PDIS_BIT = 0;
  localparam int PAGE_LSB = 9;
  localparam int IRQ_CCF = 0;
  localparam int IRQ_ACCERR = 1;
  localparam int IRQ_PVIOL = 2;
  // command codes
  localparam logic [7:0] CMD_BLANK = 8'h05;
  localparam logic [7:0] CMD_BYTE = 8'h20;
  localparam logic [7:0] CMD_BURST = 8'h25;
  localparam logic [7:0] CMD_PAGE = 8'h40;
  localparam logic [7:0] CMD_MASS = 8'h41;
  // constants and reset values
  localparam logic [1:0] SEC_UNSECURED = 2'h2;
  localparam logic [15:0] KEY_BASE = 16'hffb0;
  localparam logic [6:0] DIV_RST = 7'h00;
  localparam logic [2:0] IRQ_RST = 3'h0;

  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] addr;
    logic [7:0] data;
  } fcsc_req_s;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_DATA = 3'b010,
    SEQ_CMD = 3'b100
  } fcsc_seq_e;
endpackage

/* src/fcsc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module fcsc_top (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // cpu writes into flash space
  input wire logic fw_valid,
  input wire logic [15:0] fw_addr,
  input wire logic [7:0] fw_data,
  // nonvolatile contents
  input wire logic [7:0] nv_protection_byte,
  input wire logic [1:0] nv_security_code,
  input wire logic [63:0] backdoor_key_bytes,
  // debug port and stop
  input wire logic dbg_prot_we,
  input wire logic [7:0] dbg_prot_data,
  input wire logic stop_req,
  // flash array
  output logic arr_start,
  output fcsc_pkg::fcsc_req_s arr_req,
  output logic arr_abort,
  input wire logic arr_done,
  input wire logic arr_blank,
  // status out
  output logic [1:0] security_code,
  output logic irq
);

  fcsc_pkg::fcsc_seq_e seq_q, seq_d;
  fcsc_pkg::fcsc_req_s req_q, run_q;
  logic loaded_q, lat_q, kwe_q, divider_loaded_q;
  logic [6:0] div_q;
  logic [7:0] prot_q, rd_byte, prdata_q;
  logic [1:0] sec_q;
  logic cbef_q, accerr_q, pviol_q, blank_q, ccf, ccf_prev_q;
  logic busy_q, pend_q, start_q, abort_q;
  logic [2:0] key_idx_q;
  logic key_ok_q;
  logic [2:0] irq_stat_q, irq_mask_q, irq_ev;
  logic wr_acc, rd_acc, wr_status, launch, cmd_wr, key_hit, key_wr, seq_wr;
  logic bad, go, pe, div_err, pv, q_err, accept, xfer, stop_hit, done_ev;
  logic acc_set, pv_set, key_unlock, mapped;

  function automatic logic legal(input logic [7:0] c);
    legal = (c == fcsc_pkg::CMD_BLANK) || (c == fcsc_pkg::CMD_PAGE) ||
            (c == fcsc_pkg::CMD_MASS) || (c == fcsc_pkg::CMD_BYTE) ||
            (c == fcsc_pkg::CMD_BURST);
  endfunction

  // apb: read data captured before the access phase completes
  assign pready = ce & penable & lat_q;
  assign wr_acc = psel & penable & pwrite & pready;
  assign rd_acc = psel & penable & !pwrite & pready;
  assign pslverr = psel & penable & !mapped;
  assign prdata = {24'h0, prdata_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_q <= 1'b0;
      prdata_q <= 8'h00;
    end else if (ce) begin
      lat_q <= psel & !(penable & pready);
      if (psel && !lat_q) begin
        prdata_q <= rd_byte;
      end
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    mapped = 1'b1;
    case (paddr)
      fcsc_pkg::OFF_CONFIG: rd_byte[fcsc_pkg::KWE_BIT] = kwe_q;
      fcsc_pkg::OFF_PROT: rd_byte = prot_q;
      fcsc_pkg::OFF_STATUS: begin
        rd_byte[fcsc_pkg::CBEF_BIT] = cbef_q;
        rd_byte[fcsc_pkg::CCF_BIT] = ccf;
        rd_byte[fcsc_pkg::PVIOL_BIT] = pviol_q;
        rd_byte[fcsc_pkg::ACCERR_BIT] = accerr_q;
        rd_byte[fcsc_pkg::BLANK_BIT] = blank_q;
      end
      fcsc_pkg::OFF_CMD: rd_byte = req_q.cmd;
      fcsc_pkg::OFF_DIV: rd_byte = {divider_loaded_q, div_q};
      fcsc_pkg::OFF_SEC: rd_byte = {6'h00, sec_q};
      fcsc_pkg::OFF_IRQ_STAT: rd_byte = {5'h00, irq_stat_q};
      fcsc_pkg::OFF_IRQ_MASK: rd_byte = {5'h00, irq_mask_q};
      default: mapped = 1'b0;
    endcase
  end

  // decode of software actions
  assign wr_status = wr_acc & (paddr == fcsc_pkg::OFF_STATUS);
  assign launch = wr_status & pwdata[fcsc_pkg::CBEF_BIT];
  assign cmd_wr = wr_acc & (paddr == fcsc_pkg::OFF_CMD);
  assign key_hit = fw_valid & (fw_addr[15:3] == fcsc_pkg::KEY_BASE[15:3]);
  assign key_wr = ce & key_hit & kwe_q;
  assign seq_wr = ce & fw_valid & !(key_hit & kwe_q);

  // command sequence: flash write, command code, launch
  always_comb begin
    seq_d = seq_q;
    bad = 1'b0;
    go = 1'b0;
    case (seq_q)
      fcsc_pkg::SEQ_IDLE: begin
        if (seq_wr) begin
          if (!cbef_q || accerr_q || pviol_q) begin
            bad = 1'b1;
          end else begin
            seq_d = fcsc_pkg::SEQ_DATA;
          end
        end else if (cmd_wr || launch) begin
          bad = 1'b1;
        end
      end
      fcsc_pkg::SEQ_DATA: begin
        if (cmd_wr && !seq_wr) begin
          if (legal(pwdata[7:0])) begin
            seq_d = fcsc_pkg::SEQ_CMD;
          end else begin
            bad = 1'b1;
            seq_d = fcsc_pkg::SEQ_IDLE;
          end
        end else if (seq_wr || launch) begin
          bad = 1'b1;
          seq_d = fcsc_pkg::SEQ_IDLE;
        end
      end
      fcsc_pkg::SEQ_CMD: begin
        if (launch && !seq_wr) begin
          go = cbef_q;
          bad = !cbef_q;
          seq_d = fcsc_pkg::SEQ_IDLE;
        end else if (seq_wr || cmd_wr) begin
          bad = 1'b1;
          seq_d = fcsc_pkg::SEQ_IDLE;
        end
      end
      default: seq_d = fcsc_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_q <= fcsc_pkg::SEQ_IDLE;
      req_q <= '0;
    end else if (ce) begin
      seq_q <= seq_d;
      if (seq_q == fcsc_pkg::SEQ_IDLE && seq_d == fcsc_pkg::SEQ_DATA) begin
        req_q.addr <= fw_addr;
        req_q.data <= fw_data;
      end
      if (seq_d == fcsc_pkg::SEQ_CMD && seq_q == fcsc_pkg::SEQ_DATA) begin
        req_q.cmd <= pwdata[7:0];
      end
    end
  end

  // launch checks; program/erase needs the divider, page above boundary refused
  assign pe = req_q.cmd != fcsc_pkg::CMD_BLANK;
  assign div_err = pe & !divider_loaded_q;
  always_comb begin
    pv = 1'b0;
    if (!prot_q[fcsc_pkg::PDIS_BIT] && pe) begin
      pv = (req_q.cmd == fcsc_pkg::CMD_MASS) ||
           (req_q.addr[15:fcsc_pkg::PAGE_LSB] > prot_q[7:1]);
    end
  end
  // a burst may queue only behind a running burst
  assign q_err = busy_q & !((run_q.cmd == fcsc_pkg::CMD_BURST) &&
                            (req_q.cmd == fcsc_pkg::CMD_BURST));
  assign accept = go & !div_err & !pv & !q_err;
  assign stop_hit = ce & stop_req & (busy_q | pend_q);
  assign acc_set = ce & (bad | (go & (div_err | (!pv & q_err))) | stop_req &
                   (busy_q | pend_q));
  assign pv_set = go & !div_err & pv;
  assign xfer = ce & pend_q & (!busy_q | arr_done) & !stop_req;
  assign done_ev = ce & busy_q & arr_done & !stop_req;

  // array engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      pend_q <= 1'b0;
      run_q <= '0;
      start_q <= 1'b0;
      abort_q <= 1'b0;
    end else if (ce) begin
      start_q <= 1'b0;
      abort_q <= 1'b0;
      if (stop_hit) begin
        busy_q <= 1'b0;
        pend_q <= 1'b0;
        abort_q <= 1'b1;
      end else begin
        if (xfer) begin
          run_q <= req_q;
          start_q <= 1'b1;
          busy_q <= 1'b1;
          pend_q <= 1'b0;
        end else if (done_ev) begin
          busy_q <= 1'b0;
        end
        if (accept) begin
          pend_q <= 1'b1;
        end
      end
    end
  end
  assign arr_start = start_q;
  assign arr_req = run_q;
  assign arr_abort = abort_q;
  assign ccf = !busy_q & !pend_q;

  // status flags; a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cbef_q <= 1'b1;
      accerr_q <= 1'b0;
      pviol_q <= 1'b0;
      blank_q <= 1'b0;
    end else if (ce) begin
      if (stop_hit || xfer) begin
        cbef_q <= 1'b1;
      end else if (accept) begin
        cbef_q <= 1'b0;
      end
      if (acc_set) begin
        accerr_q <= 1'b1;
      end else if (wr_status && pwdata[fcsc_pkg::ACCERR_BIT]) begin
        accerr_q <= 1'b0;
      end
      if (pv_set) begin
        pviol_q <= 1'b1;
      end else if (wr_status && pwdata[fcsc_pkg::PVIOL_BIT]) begin
        pviol_q <= 1'b0;
      end
      if (accept) begin
        blank_q <= 1'b0;
      end else if (done_ev && run_q.cmd == fcsc_pkg::CMD_BLANK) begin
        blank_q <= arr_blank;
      end
    end
  end

  // config and divider registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kwe_q <= 1'b0;
      div_q <= fcsc_pkg::DIV_RST;
      divider_loaded_q <= 1'b0;
    end else if (wr_acc) begin
      if (paddr == fcsc_pkg::OFF_CONFIG) begin
        kwe_q <= pwdata[fcsc_pkg::KWE_BIT];
      end
      if (paddr == fcsc_pkg::OFF_DIV) begin
        div_q <= pwdata[6:0];
        divider_loaded_q <= 1'b1;
      end
    end
  end

  // protection and security loaded from flash on the first enabled edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded_q <= 1'b0;
      prot_q <= 8'h00;
    end else if (ce) begin
      if (!loaded_q) begin
        loaded_q <= 1'b1;
        prot_q <= nv_protection_byte;
      end else if (dbg_prot_we) begin
        prot_q <= dbg_prot_data;
      end
    end
  end

  // backdoor key: eight bytes in address order, all must match
  assign key_unlock = key_wr & (fw_addr[2:0] == key_idx_q) & (key_idx_q == 3'h7) &
                      key_ok_q & (fw_data == backdoor_key_bytes[63:56]);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_idx_q <= 3'h0;
      key_ok_q <= 1'b1;
    end else if (key_wr) begin
      if (fw_addr[2:0] == key_idx_q && key_idx_q != 3'h7) begin
        key_idx_q <= key_idx_q + 3'h1;
        key_ok_q <= key_ok_q & (fw_data == backdoor_key_bytes[8*key_idx_q +: 8]);
      end else begin
        key_idx_q <= 3'h0;
        key_ok_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_q <= 2'h0;
    end else if (ce) begin
      if (!loaded_q) begin
        sec_q <= nv_security_code;
      end else if (key_unlock ||
                   (done_ev && run_q.cmd == fcsc_pkg::CMD_BLANK && arr_blank)) begin
        sec_q <= fcsc_pkg::SEC_UNSECURED;
      end
    end
  end
  // any code but 2'b10 keeps the part secure
  assign security_code = sec_q;

  // interrupts: read of irq status clears, events win
  assign irq_ev = {pv_set, acc_set, ce & ccf & !ccf_prev_q};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= fcsc_pkg::IRQ_RST;
      irq_mask_q <= fcsc_pkg::IRQ_RST;
      ccf_prev_q <= 1'b1;
    end else if (ce) begin
      ccf_prev_q <= ccf;
      if (rd_acc && paddr == fcsc_pkg::OFF_IRQ_STAT) begin
        irq_stat_q <= irq_ev;
      end else begin
        irq_stat_q <= irq_stat_q | irq_ev;
      end
      if (wr_acc && paddr == fcsc_pkg::OFF_IRQ_MASK) begin
        irq_mask_q <= pwdata[2:0];
      end
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_BLANK_UNLOCK: assert property (
    done_ev && run_q.cmd == fcsc_pkg::CMD_BLANK && arr_blank |=>
      security_code == fcsc_pkg::SEC_UNSECURED && blank_q)
    else $error("blank pass did not unsecure");
  AST_SEQ_START: assert property (
    seq_wr && seq_q == fcsc_pkg::SEQ_IDLE && cbef_q && !accerr_q && !pviol_q |=>
      seq_q == fcsc_pkg::SEQ_DATA)
    else $error("flash write did not start sequence");
  AST_KEY_ROUTE: assert property (
    key_wr && !cmd_wr && !launch |=>
      $stable(seq_q) && (!accerr_q || $past(accerr_q) || $past(stop_hit)))
    else $error("key write disturbed command sequence");
  AST_PROT_RO: assert property (
    loaded_q && wr_acc && paddr == fcsc_pkg::OFF_PROT && !dbg_prot_we |=> $stable(prot_q))
    else $error("user write changed protection");
  AST_DBG_PROT: assert property (
    ce && loaded_q && dbg_prot_we |=> prot_q == $past(dbg_prot_data))
    else $error("debug write not taken");
  AST_LAUNCH: assert property (
    accept && !busy_q |=> (!cbef_q && !ccf) and ((ce && !stop_req) |=> arr_start))
    else $error("launch did not reach array");
  AST_ACC_HOLD: assert property (
    accerr_q && !(wr_status && pwdata[fcsc_pkg::ACCERR_BIT]) |=> accerr_q)
    else $error("access error cleared without write 1");
  AST_ILLEGAL: assert property (
    ce && cmd_wr && !seq_wr && seq_q == fcsc_pkg::SEQ_DATA && !legal(pwdata[7:0]) |=>
      accerr_q && seq_q == fcsc_pkg::SEQ_IDLE)
    else $error("illegal code not rejected");
  AST_NO_DIV: assert property (
    go && pe && !divider_loaded_q |=> accerr_q && !pend_q ##1 !arr_start)
    else $error("program ran without divider");
  AST_PVIOL: assert property (
    pv_set |=> pviol_q && !pend_q)
    else $error("protected target not refused");
  COV_BURST_QUEUE: cover property (accept && busy_q);
  COV_UNLOCK_KEY: cover property (key_unlock);
  COV_STOP_ABORT: cover property (stop_hit);

endmodule
`default_nettype wire

/* verification/fcsc_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fcsc_flash_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // command side
  input wire logic arr_start,
  input wire logic arr_abort,
  output logic arr_done,
  output logic arr_blank,
  // scenario controls
  input wire logic slow,
  input wire logic blank_in
);
  logic [5:0] cnt_q;
  logic busy_q;
  logic tog_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      cnt_q <= 6'h00;
      arr_done <= 1'b0;
      tog_q <= 1'b0;
    end else begin
      arr_done <= 1'b0;
      tog_q <= ~tog_q;
      if (arr_abort) begin
        busy_q <= 1'b0;
      end else if (arr_start) begin
        busy_q <= 1'b1;
        cnt_q <= slow ? 6'h28 : 6'h03;
      end else if (busy_q && cnt_q == 6'h00) begin
        busy_q <= 1'b0;
        arr_done <= 1'b1;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 6'h01;
      end
    end
  end
  // result only meaningful with done; toggles otherwise so stale reads show
  assign arr_blank = arr_done ? blank_in : tog_q;
endmodule
`default_nettype wire

/* verification/tb_flash_command_status_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_flash_command_status_control;
  logic pclk, presetn, ce, psel, penable, pwrite, fw_valid, dbg_prot_we, stop_req;
  logic pready, pslverr, arr_start, arr_abort, arr_done, arr_blank, irq, slow, blank_in, hit, e;
  logic [7:0] paddr, fw_data, nv_protection_byte, dbg_prot_data, r;
  logic [31:0] pwdata, prdata;
  logic [15:0] fw_addr;
  logic [63:0] backdoor_key_bytes;
  logic [1:0] nv_security_code, security_code;
  fcsc_pkg::fcsc_req_s arr_req;
  logic [7:0] codes [4];
  int fails, checked;

  always #2.5 pclk = ~pclk;

  fcsc_top i_dut (.pclk, .presetn, .ce, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .fw_valid, .fw_addr, .fw_data, .nv_protection_byte, .nv_security_code,
    .backdoor_key_bytes, .dbg_prot_we, .dbg_prot_data, .stop_req, .arr_start, .arr_req,
    .arr_abort, .arr_done, .arr_blank, .security_code, .irq);
  fcsc_flash_model i_arr (.pclk, .presetn, .arr_start, .arr_abort, .arr_done, .arr_blank,
    .slow, .blank_in);

  task automatic report_and_stop();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      report_and_stop();
    end
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    apb(1'b0, a, 8'h00);
    chk(n, e, r);
  endtask

  task automatic st(input logic [7:0] e);
    rd(fcsc_pkg::OFF_STATUS, e, "status");
  endtask

  task automatic wst(input logic [7:0] d);
    apb(1'b1, fcsc_pkg::OFF_STATUS, d);
  endtask

  task automatic fw(input logic [15:0] a, input logic [7:0] d);
    @(posedge pclk);
    fw_valid <= 1'b1;
    fw_addr <= a;
    fw_data <= d;
    @(posedge pclk);
    fw_valid <= 1'b0;
  endtask

  task automatic launch(input logic [15:0] a, input logic [7:0] c);
    fw(a, 8'h3c);
    apb(1'b1, fcsc_pkg::OFF_CMD, c);
    wst(8'h80);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    r = 8'h00;
    while (r[6] !== 1'b1) begin
      apb(1'b0, fcsc_pkg::OFF_STATUS, 8'h00);
      n++;
      if (n > 100) begin
        fails++;
        report_and_stop();
      end
    end
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fw_valid = 1'b0;
    fw_addr = 16'h0000;
    fw_data = 8'h00;
    nv_protection_byte = 8'h7a;
    nv_security_code = 2'h3;
    backdoor_key_bytes = 64'ha7a6a5a4a3a2a1a0;
    dbg_prot_we = 1'b0;
    dbg_prot_data = 8'h00;
    stop_req = 1'b0;
    slow = 1'b0;
    blank_in = 1'b0;
    codes = '{fcsc_pkg::CMD_BLANK, fcsc_pkg::CMD_BYTE, fcsc_pkg::CMD_BURST, fcsc_pkg::CMD_PAGE};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    st(8'hc0);
    rd(fcsc_pkg::OFF_PROT, 8'h7a, "prot");
    chk("secure", 8'h03, {6'h00, security_code});
    apb(1'b1, fcsc_pkg::OFF_PROT, 8'h55);
    rd(fcsc_pkg::OFF_PROT, 8'h7a, "prot");
    // program before any divider write must be refused
    launch(16'h0200, fcsc_pkg::CMD_BYTE);
    st(8'hd0);
    wst(8'h40);
    st(8'hd0);
    wst(8'h10);
    st(8'hc0);
    apb(1'b1, fcsc_pkg::OFF_DIV, 8'h05);
    rd(fcsc_pkg::OFF_DIV, 8'h85, "div");
    apb(1'b1, fcsc_pkg::OFF_CONFIG, 8'h20);
    for (int i = 0; i < 8; i++) begin
      fw(16'hffb0 + 16'(i), 8'ha0 + 8'(i));
    end
    repeat (2) @(posedge pclk);
    chk("unsecured", 8'h02, {6'h00, security_code});
    st(8'hc0);
    apb(1'b1, fcsc_pkg::OFF_CONFIG, 8'h00);
    // key area now starts a command, and that page sits above the boundary
    launch(16'hffb0, fcsc_pkg::CMD_BYTE);
    st(8'he0);
    wst(8'h20);
    st(8'hc0);
    foreach (codes[i]) begin
      launch(16'h0200, codes[i]);
      wait_idle();
      chk("cmd", codes[i], arr_req.cmd);
      st(8'hc0);
    end
    launch(16'h0200, fcsc_pkg::CMD_MASS);
    st(8'he0);
    wst(8'h20);
    @(posedge pclk);
    dbg_prot_we <= 1'b1;
    dbg_prot_data <= 8'h01;
    @(posedge pclk);
    dbg_prot_we <= 1'b0;
    rd(fcsc_pkg::OFF_PROT, 8'h01, "prot");
    launch(16'hfe00, fcsc_pkg::CMD_MASS);
    wait_idle();
    chk("cmd", fcsc_pkg::CMD_MASS, arr_req.cmd);
    chk("data", 8'h3c, arr_req.data);
    blank_in <= 1'b1;
    launch(16'h0000, fcsc_pkg::CMD_BLANK);
    wait_idle();
    st(8'hc4);
    launch(16'h0000, fcsc_pkg::CMD_BYTE);
    wait_idle();
    st(8'hc0);
    codes = '{8'h00, 8'h21, 8'h42, 8'hff};
    foreach (codes[i]) begin
      launch(16'h0200, codes[i]);
      st(8'hd0);
      wst(8'h10);
    end
    // slow array so the second burst has to wait in the buffer
    slow <= 1'b1;
    launch(16'h0200, fcsc_pkg::CMD_BURST);
    launch(16'h0201, fcsc_pkg::CMD_BURST);
    st(8'h00);
    wait_idle();
    chk("addr", 8'h01, arr_req.addr[7:0]);
    launch(16'h0200, fcsc_pkg::CMD_BURST);
    launch(16'h0201, fcsc_pkg::CMD_BYTE);
    st(8'h90);
    wait_idle();
    wst(8'h10);
    launch(16'h0200, fcsc_pkg::CMD_BYTE);
    stop_req <= 1'b1;
    hit = 1'b0;
    repeat (8) begin
      @(posedge pclk);
      if (arr_abort === 1'b1) begin
        hit = 1'b1;
      end
    end
    stop_req <= 1'b0;
    chk("abort", 8'h01, {7'h00, hit});
    st(8'hd0);
    wst(8'h10);
    slow <= 1'b0;
    // flash write while frozen is lost, so the command write is out of order
    ce <= 1'b0;
    fw(16'h0200, 8'h3c);
    ce <= 1'b1;
    apb(1'b1, fcsc_pkg::OFF_CMD, fcsc_pkg::CMD_BYTE);
    st(8'hd0);
    wst(8'h10);
    apb(1'b1, fcsc_pkg::OFF_IRQ_MASK, 8'h01);
    apb(1'b0, fcsc_pkg::OFF_IRQ_STAT, 8'h00);
    @(posedge pclk);
    chk("irq", 8'h00, {7'h00, irq});
    launch(16'h0200, fcsc_pkg::CMD_BYTE);
    wait_idle();
    chk("irq", 8'h01, {7'h00, irq});
    rd(fcsc_pkg::OFF_IRQ_STAT, 8'h01, "irq_stat");
    @(posedge pclk);
    chk("irq", 8'h00, {7'h00, irq});
    rd(8'h40, 8'h00, "unmapped");
    chk("pslverr", 8'h01, {7'h00, e});
    report_and_stop();
  end
endmodule
`default_nettype wire
